// ### core/oerc_pkg.sv
// Shared constants and carriers for the output enable and remote control block.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package oerc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam logic [7:0] ADDR_OUT_STATE  = 8'h00;
  localparam logic [7:0] ADDR_PIN_POLICY = 8'h04;
  localparam logic [7:0] ADDR_LOAD_TYPE  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
  localparam logic [7:0] ADDR_ERR_CODE   = 8'h14;
  localparam logic [7:0] ADDR_SAVE       = 8'h18;
  localparam logic [7:0] ADDR_PIN_STATE  = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // Field layouts and codes.
  localparam int POL_W   = 3;
  localparam int LOAD_W  = 2;
  localparam int EVT_W   = 3;
  localparam int EVT_CONFLICT = 0;
  localparam int EVT_LATCHOFF = 1;
  localparam int EVT_CHANGE   = 2;

  localparam logic [POL_W-1:0] POL_PIN_HIGH_ENABLES  = 3'h0;
  localparam logic [POL_W-1:0] POL_PIN_LOW_ENABLES   = 3'h1;
  localparam logic [POL_W-1:0] POL_PIN_HIGH_DISABLES = 3'h2;
  localparam logic [POL_W-1:0] POL_PIN_LOW_DISABLES  = 3'h3;
  localparam logic [POL_W-1:0] POL_LOW_PULSE_LATCH   = 3'h4;
  localparam logic [POL_W-1:0] POL_PIN_IGNORED       = 3'h5;

  localparam logic [LOAD_W-1:0] LOAD_ACTIVE    = 2'h0;
  localparam logic [LOAD_W-1:0] LOAD_RESISTIVE = 2'h1;
  localparam logic [LOAD_W-1:0] LOAD_BATTERY   = 2'h2;

  localparam logic [31:0] ERR_SETTINGS_CONFLICT = 32'hFFFFFF23;
  localparam logic [31:0] ERR_NONE              = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [POL_W-1:0]  RST_POLICY = POL_PIN_HIGH_DISABLES;
  localparam logic [LOAD_W-1:0] RST_LOAD   = LOAD_ACTIVE;
  localparam logic [EVT_W-1:0]  RST_MASK   = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int LP_TIME_NS    = 100000;
  localparam int LP_CYC        = (LP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus carriers.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } oerc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } oerc_apb_rsp_t;

endpackage

// ### core/oerc_top.sv
// Output enable control: host commands, remote on/off pin policy, load type.
// Assumes an APB master on clk_i; the setup, memory and list inputs come from
// logic on the same clock, while the remote pin is asynchronous.
//
// Notes on behaviour
// - Host command turns output on or off.
// - Power-up output on, analog control on.
// - Reject command with error -221 on conflicts.
// - State query answers zero or one.
// - Six pin policies, default high disables, savable.
// - High enables: pin level drives output.
// - Low enables: inverted pin drives output.
// - High disables: high pin forces off.
// - Low disables: low pin forces off.
// - Low pulse latches output off until command.
// - Ignored policy disregards the pin entirely.
// - Level policies make host commands ineffective.
// - Policy query returns configured policy.
// - Store load type: active, resistive, battery.
// - Load type query returns stored type.
//
// The placing of the registers and the APB slave port are this design's own decisions.
module oerc_top
  import oerc_pkg::*;
#(
  parameter int LP_CYCLES = LP_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                en_i,
  input  wire oerc_apb_req_t       apb_req_i,
  output oerc_apb_rsp_t            apb_rsp_o,
  input  wire logic                remote_pin_i,
  input  wire logic                panel_on_i,
  input  wire logic                list_running_i,
  input  wire logic                setup_out_off_i,
  input  wire logic                setup_analog_off_i,
  input  wire logic                nv_policy_valid_i,
  input  wire logic [POL_W-1:0]    nv_policy_i,
  output logic                     output_en_o,
  output logic                     analog_ctl_en_o,
  output logic [LOAD_W-1:0]        load_type_o,
  output logic                     save_req_o,
  output logic [POL_W-1:0]         save_policy_o,
  output logic                     irq_o
);

  localparam int CNT_W = $clog2(LP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_SAT  = CNT_W'(LP_CYCLES);

  ////////////////////////////////////////////////////////////////////////////////
  // Remote pin synchroniser. An open pin reads high through the external pull-up.
  logic pin_meta_q;
  logic pin_s_q;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_meta_q <= 1'b1;
      pin_s_q    <= 1'b1;
    end else if (en_i) begin
      pin_meta_q <= remote_pin_i;
      pin_s_q    <= pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave. The read answer is prepared in the setup cycle, so every access
  // completes after exactly one access cycle.
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        setup_ph;
  logic        wr_acc;
  logic [7:0]  acc_addr;
  logic [31:0] wdata;
  logic        mapped;

  // Core state declared early because the read mux looks at it.
  logic                  boot_done_q;
  logic                  boot_done_d;
  logic                  out_q;
  logic                  out_d;
  logic                  analog_q;
  logic                  analog_d;
  logic [POL_W-1:0]      policy_q;
  logic [POL_W-1:0]      policy_d;
  logic [LOAD_W-1:0]     load_q;
  logic [LOAD_W-1:0]     load_d;
  logic [EVT_W-1:0]      sts_q;
  logic [EVT_W-1:0]      sts_d;
  logic [EVT_W-1:0]      mask_q;
  logic [EVT_W-1:0]      mask_d;
  logic [31:0]           err_q;
  logic [31:0]           err_d;
  logic                  irq_q;
  logic                  irq_d;
  logic                  save_q;
  logic                  save_d;
  logic [POL_W-1:0]      save_pol_q;
  logic [POL_W-1:0]      save_pol_d;
  logic [CNT_W-1:0]      low_cnt_q;
  logic [CNT_W-1:0]      low_cnt_d;

  assign setup_ph = apb_req_i.psel && !apb_req_i.penable;
  assign wr_acc   = en_i && apb_req_i.psel && apb_req_i.penable && pready_q &&
                    apb_req_i.pwrite && !pslverr_q;
  assign acc_addr = apb_req_i.paddr;
  assign wdata    = apb_req_i.pwdata;

  always_comb begin
    mapped = 1'b1;
    prdata_d = 32'h00000000;
    unique case (acc_addr)
      ADDR_OUT_STATE:  prdata_d[0] = out_q;
      ADDR_PIN_POLICY: prdata_d[POL_W-1:0] = policy_q;
      ADDR_LOAD_TYPE:  prdata_d[LOAD_W-1:0] = load_q;
      ADDR_IRQ_STATUS: prdata_d[EVT_W-1:0] = sts_q;
      ADDR_IRQ_MASK:   prdata_d[EVT_W-1:0] = mask_q;
      ADDR_ERR_CODE:   prdata_d = err_q;
      ADDR_SAVE:       prdata_d = 32'h00000000;
      ADDR_PIN_STATE:  prdata_d[1:0] = {analog_q, pin_s_q};
      default:         mapped = 1'b0;
    endcase
    if (setup_ph && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      if (!apb_req_i.pwrite) begin
        prdata_d = mapped ? prdata_d : 32'h00000000;
      end else begin
        prdata_d = 32'h00000000;
      end
    end else begin
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (en_i) begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output control core.
  logic pin_high;
  logic cmd_wr;
  logic cmd_val;
  logic level_pol;
  logic conflict;
  logic cmd_ok;
  logic panel_ok;
  logic lp_fire;

  assign pin_high  = pin_s_q;
  assign cmd_wr    = wr_acc && (acc_addr == ADDR_OUT_STATE) && boot_done_q;
  assign cmd_val   = wdata[0];
  assign level_pol = (policy_q == POL_PIN_HIGH_ENABLES) ||
                     (policy_q == POL_PIN_LOW_ENABLES);
  // The disabling condition of the two disable policies counts as a conflict.
  assign conflict  = level_pol || list_running_i ||
                     ((policy_q == POL_PIN_HIGH_DISABLES) && pin_high) ||
                     ((policy_q == POL_PIN_LOW_DISABLES) && !pin_high);
  assign cmd_ok    = cmd_wr && !conflict;
  assign panel_ok  = en_i && panel_on_i && boot_done_q && !conflict;
  assign lp_fire   = (policy_q == POL_LOW_PULSE_LATCH) && !pin_high &&
                     (low_cnt_q == CNT_LAST);

  always_comb begin
    boot_done_d = 1'b1;
    out_d       = out_q;
    analog_d    = analog_q;
    policy_d    = policy_q;
    load_d      = load_q;
    mask_d      = mask_q;
    err_d       = err_q;
    save_d      = 1'b0;
    save_pol_d  = save_pol_q;
    low_cnt_d   = low_cnt_q;
    sts_d       = sts_q;

    if (!boot_done_q) begin
      // Power-up defaults, unless the setup switches or saved policy say otherwise.
      out_d    = !setup_out_off_i;
      analog_d = !setup_analog_off_i;
      if (nv_policy_valid_i && (nv_policy_i <= POL_PIN_IGNORED)) begin
        policy_d = nv_policy_i;
      end
    end else begin
      if (cmd_ok) begin
        out_d = cmd_val;
      end else if (panel_ok) begin
        out_d = 1'b1;
      end

      if (policy_q == POL_LOW_PULSE_LATCH && !pin_high) begin
        low_cnt_d = (low_cnt_q == CNT_SAT) ? CNT_SAT : low_cnt_q + 1'b1;
      end else begin
        low_cnt_d = '0;
      end

      unique case (policy_q)
        POL_PIN_HIGH_ENABLES:  out_d = pin_high;
        POL_PIN_LOW_ENABLES:   out_d = !pin_high;
        POL_PIN_HIGH_DISABLES: if (pin_high) out_d = 1'b0;
        POL_PIN_LOW_DISABLES:  if (!pin_high) out_d = 1'b0;
        // A latched off is cleared only by a later ON command, never by the pin.
        POL_LOW_PULSE_LATCH:   if (lp_fire) out_d = 1'b0;
        default:               out_d = out_d;
      endcase

      if (wr_acc) begin
        unique case (acc_addr)
          ADDR_PIN_POLICY: begin
            if (wdata[POL_W-1:0] <= POL_PIN_IGNORED) policy_d = wdata[POL_W-1:0];
          end
          ADDR_LOAD_TYPE: begin
            if (wdata[LOAD_W-1:0] <= LOAD_BATTERY) load_d = wdata[LOAD_W-1:0];
          end
          ADDR_IRQ_STATUS: sts_d = sts_q & ~wdata[EVT_W-1:0];
          ADDR_IRQ_MASK:   mask_d = wdata[EVT_W-1:0];
          ADDR_ERR_CODE:   err_d = ERR_NONE;
          ADDR_SAVE: begin
            save_d     = wdata[0];
            save_pol_d = wdata[0] ? policy_q : save_pol_q;
          end
          default: begin
          end
        endcase
      end

      // Events are set after the clear so that a coincident event is kept.
      if (cmd_wr && conflict) begin
        sts_d[EVT_CONFLICT] = 1'b1;
        err_d = ERR_SETTINGS_CONFLICT;
      end
      if (lp_fire) sts_d[EVT_LATCHOFF] = 1'b1;
      if (out_d != out_q) sts_d[EVT_CHANGE] = 1'b1;
    end
    irq_d = |(sts_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      boot_done_q <= 1'b0;
      out_q       <= 1'b1;
      analog_q    <= 1'b1;
      policy_q    <= RST_POLICY;
      load_q      <= RST_LOAD;
      sts_q       <= '0;
      mask_q      <= RST_MASK;
      err_q       <= ERR_NONE;
      irq_q       <= 1'b0;
      save_q      <= 1'b0;
      save_pol_q  <= RST_POLICY;
      low_cnt_q   <= '0;
    end else if (en_i) begin
      boot_done_q <= boot_done_d;
      out_q       <= out_d;
      analog_q    <= analog_d;
      policy_q    <= policy_d;
      load_q      <= load_d;
      sts_q       <= sts_d;
      mask_q      <= mask_d;
      err_q       <= err_d;
      irq_q       <= irq_d;
      save_q      <= save_d;
      save_pol_q  <= save_pol_d;
      low_cnt_q   <= low_cnt_d;
    end
  end

  assign apb_rsp_o.pready  = pready_q;
  assign apb_rsp_o.pslverr = pslverr_q;
  assign apb_rsp_o.prdata  = prdata_q;
  assign output_en_o       = out_q;
  assign analog_ctl_en_o   = analog_q;
  assign load_type_o       = load_q;
  assign save_req_o        = save_q;
  assign save_policy_o     = save_pol_q;
  assign irq_o             = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic run;
  assign run = en_i && boot_done_q;

  property p_cmd_sets;
    (run && cmd_ok && !lp_fire) |=> (out_q == $past(cmd_val));
  endproperty
  a_cmd_sets: assert property (p_cmd_sets) else $error("accepted command not applied");

  property p_conflict;
    (run && cmd_wr && conflict) |=> (sts_q[EVT_CONFLICT] && err_q == ERR_SETTINGS_CONFLICT);
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not reported");

  property p_level_cmd_void;
    (run && level_pol && cmd_wr) |=> (out_q == $past(pin_high) ^ $past(policy_q[0]));
  endproperty
  a_level_cmd_void: assert property (p_level_cmd_void) else $error("command moved output");

  property p_query_state;
    (en_i && setup_ph && !pready_q && !apb_req_i.pwrite && acc_addr == ADDR_OUT_STATE)
      |=> (prdata_q == {31'h00000000, $past(out_q)} && pready_q);
  endproperty
  a_query_state: assert property (p_query_state) else $error("state query wrong");

  property p_hi_en;
    (run && policy_q == POL_PIN_HIGH_ENABLES) |=> (out_q == $past(pin_s_q));
  endproperty
  a_hi_en: assert property (p_hi_en) else $error("output not following pin");

  property p_lo_en;
    (run && policy_q == POL_PIN_LOW_ENABLES) |=> (out_q == !$past(pin_s_q));
  endproperty
  a_lo_en: assert property (p_lo_en) else $error("output not following inverted pin");

  property p_hi_dis;
    (run && policy_q == POL_PIN_HIGH_DISABLES && pin_s_q) |=> !out_q;
  endproperty
  a_hi_dis: assert property (p_hi_dis) else $error("high pin did not force off");

  property p_lo_dis;
    (run && policy_q == POL_PIN_LOW_DISABLES && !pin_s_q) |=> !out_q;
  endproperty
  a_lo_dis: assert property (p_lo_dis) else $error("low pin did not force off");

  property p_latch_hold;
    (run && policy_q == POL_LOW_PULSE_LATCH && !out_q && !cmd_ok && !panel_ok) |=> !out_q;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched off released");

  property p_latch_fire;
    (run && lp_fire) |=> (!out_q && sts_q[EVT_LATCHOFF]);
  endproperty
  a_latch_fire: assert property (p_latch_fire) else $error("low pulse did not latch off");

  property p_ignore;
    (run && policy_q == POL_PIN_IGNORED && !cmd_ok && !panel_ok) |=> $stable(out_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored pin moved output");

  property p_sync;
    (en_i ##1 en_i) |=> (pin_s_q == $past(remote_pin_i, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("pin synchroniser depth wrong");

  property p_save;
    (run && wr_acc && acc_addr == ADDR_SAVE && wdata[0]) |=> (save_q && save_pol_q == $past(policy_q));
  endproperty
  a_save: assert property (p_save) else $error("save request not issued");

  property p_load;
    (run && wr_acc && acc_addr == ADDR_LOAD_TYPE && wdata[LOAD_W-1:0] <= LOAD_BATTERY)
      |=> (load_q == $past(wdata[LOAD_W-1:0]));
  endproperty
  a_load: assert property (p_load) else $error("load type not stored");

  c_cmd_on:    cover property (run && cmd_ok && cmd_val);
  c_conflict:  cover property (run && cmd_wr && conflict);
  c_latch:     cover property (run && lp_fire);
  c_irq:       cover property ($rose(irq_q));

endmodule

// ### testbench/oerc_pin_drv.sv
// Far-side model of the remote on/off pin driver on the trigger connector.
// Assumes the caller enters drive just after a rising edge of clk_i.
module oerc_pin_drv (
  input  wire logic clk_i,
  output logic      remote_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // An open pin reads high through the external pull-up, so released means high.
  initial remote_pin_o = 1'b1;

  // Holds a level for a whole number of cycles; a low held long enough is a latch-off pulse.
  task automatic drive(input logic lvl, input int cycles);
    remote_pin_o <= lvl;
    repeat (cycles) @(posedge clk_i);
  endtask
endmodule

// ### testbench/oerc_tb.sv
// Self-checking bench for the output enable block: APB master, pin driver, panel pulses.
// Expects the block to answer every APB access in the first access cycle after the setup phase.
module testbench
  import oerc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LPN = 8;
  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic              list_running_i = 1'b0;
  logic              panel_on_i = 1'b0;
  logic              en_i = 1'b1;
  logic              setup_out_off_i = 1'b0;
  logic              setup_analog_off_i = 1'b0;
  logic              nv_policy_valid_i = 1'b0;
  logic [POL_W-1:0]  nv_policy_i = '0;
  oerc_apb_req_t     req = '0;
  oerc_apb_rsp_t     rsp;
  logic              remote_pin;
  logic              output_en_o;
  logic              analog_ctl_en_o;
  logic              save_req_o;
  logic              irq_o;
  logic [LOAD_W-1:0] load_type_o;
  logic [POL_W-1:0]  save_policy_o;
  logic [31:0]       rd_q;
  logic              err_q;
  logic [31:0]       lfsr = 32'hF8B67301;
  int                n_errors = 0;
  int                n_compared = 0;
  int                exp_out;
  int                pol;
  int                pin;
  int                k;

  always #50 clk_i = ~clk_i;

  oerc_pin_drv u_pin (.clk_i(clk_i), .remote_pin_o(remote_pin));

  oerc_top #(.LP_CYCLES(LPN)) DUT (
    .clk_i              (clk_i),
    .rstn_i             (rstn_i),
    .en_i               (en_i),
    .apb_req_i          (req),
    .apb_rsp_o          (rsp),
    .remote_pin_i       (remote_pin),
    .panel_on_i         (panel_on_i),
    .list_running_i     (list_running_i),
    .setup_out_off_i    (setup_out_off_i),
    .setup_analog_off_i (setup_analog_off_i),
    .nv_policy_valid_i  (nv_policy_valid_i),
    .nv_policy_i        (nv_policy_i),
    .output_en_o        (output_en_o),
    .analog_ctl_en_o    (analog_ctl_en_o),
    .load_type_o        (load_type_o),
    .save_req_o         (save_req_o),
    .save_policy_o      (save_policy_o),
    .irq_o              (irq_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      n_errors++;
    end
  endtask

  // Request is held until pready is seen high at a rising edge, then released.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1);
    chk(n, 32'h1, "pready wait");
    rd_q = rsp.prdata;
    err_q = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp, what);
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Level policies follow the pin; disabling policies only force off; others hold.
  function automatic int pol_eff(input int p, input int pn, input int o);
    case (p)
      0: return pn;
      1: return pn == 0;
      2: return pn != 0 ? 0 : o;
      3: return pn != 0 ? o : 0;
      default: return o;
    endcase
  endfunction

  task automatic command(input int c, input bit panel);
    if (panel) begin
      panel_on_i <= 1'b1;
      @(posedge clk_i);
      panel_on_i <= 1'b0;
    end else begin
      apb(1'b1, ADDR_OUT_STATE, 32'(c));
    end
    repeat (3) @(posedge clk_i);
    if (!(list_running_i || pol < 2 || (pol == 2 && pin != 0) || (pol == 3 && pin == 0))) begin
      exp_out = c;
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("Error at %0t ns: watchdog expired", $time);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    chk({30'h0, analog_ctl_en_o, output_en_o}, 32'h3, "power-up state");
    rstn_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    pol = 2;
    pin = 1;
    exp_out = 0;
    chk({31'h0, output_en_o}, exp_out, "high pin forces off");
    rd(ADDR_PIN_POLICY, 32'h2, "default policy");
    rd(ADDR_IRQ_MASK, 32'h0, "default mask");
    rd(ADDR_LOAD_TYPE, 32'h0, "default load");
    rd(ADDR_PIN_STATE, 32'h3, "pin state after reset");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_LOAD_TYPE, 32'(i));
      rd(ADDR_LOAD_TYPE, (i > 2) ? 32'h2 : 32'(i), "load query");
      chk({30'h0, load_type_o}, (i > 2) ? 32'h2 : 32'(i), "load output");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err_q}, 32'h1, "unmapped error");
    for (int i = 0; i < 6; i++) begin
      pol = i;
      apb(1'b1, ADDR_PIN_POLICY, 32'(i));
      rd(ADDR_PIN_POLICY, 32'(i), "policy query");
      exp_out = pol_eff(pol, pin, exp_out);
      chk({31'h0, output_en_o}, exp_out, "policy with high pin");
    end
    apb(1'b1, ADDR_SAVE, 32'h1);
    k = 0;
    while (save_req_o !== 1'b1 && k < 4) begin
      @(posedge clk_i);
      k++;
    end
    chk({31'h0, save_req_o}, 32'h1, "save pulse");
    chk({29'h0, save_policy_o}, 32'h5, "saved policy");
    // Conflict through a running list, with the interrupt masked in and then cleared.
    list_running_i <= 1'b1;
    apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    command(1, 1'b0);
    chk({31'h0, output_en_o}, exp_out, "list blocks command");
    rd(ADDR_ERR_CODE, 32'hFFFFFF23, "conflict code");
    chk({31'h0, irq_o}, 32'h1, "conflict interrupt");
    apb(1'b1, ADDR_ERR_CODE, 32'h0);
    rd(ADDR_ERR_CODE, 32'h0, "error code cleared");
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0, "interrupt cleared");
    list_running_i <= 1'b0;
    // Latch-off: one sample short of the limit is ignored, the full limit latches.
    pol = 4;
    apb(1'b1, ADDR_PIN_POLICY, 32'h4);
    command(1, 1'b0);
    chk({31'h0, output_en_o}, exp_out, "on command");
    u_pin.drive(1'b0, LPN - 1);
    u_pin.drive(1'b1, 5);
    chk({31'h0, output_en_o}, 32'h1, "short low pulse");
    u_pin.drive(1'b0, LPN);
    u_pin.drive(1'b1, 12);
    chk({31'h0, output_en_o}, 32'h0, "latched off");
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd_q & 32'h2, 32'h2, "latch-off event");
    exp_out = 0;
    command(1, 1'b0);
    chk({31'h0, output_en_o}, exp_out, "on after latch-off");
    // Random policy, pin level and command source against the model.
    for (int i = 0; i < 30; i++) begin
      lfsr = nxt(lfsr);
      pol = (lfsr[3:0] % 5 == 4) ? 5 : lfsr[3:0] % 5;
      apb(1'b1, ADDR_PIN_POLICY, 32'(pol));
      exp_out = pol_eff(pol, pin, exp_out);
      pin = lfsr[8];
      u_pin.drive(lfsr[8], 4);
      exp_out = pol_eff(pol, pin, exp_out);
      chk({31'h0, output_en_o}, exp_out, "pin policy");
      command(lfsr[10] | lfsr[9], lfsr[10]);
      chk({31'h0, output_en_o}, exp_out, "command gating");
      rd(ADDR_OUT_STATE, exp_out, "state query");
    end
    // Clock enable low freezes the synchroniser and the output.
    apb(1'b1, ADDR_PIN_POLICY, 32'(POL_PIN_HIGH_ENABLES));
    u_pin.drive(1'b1, 4);
    chk({31'h0, output_en_o}, 32'h1, "high pin enables");
    en_i <= 1'b0;
    u_pin.drive(1'b0, 6);
    chk({31'h0, output_en_o}, 32'h1, "frozen output");
    en_i <= 1'b1;
    u_pin.drive(1'b0, 4);
    chk({31'h0, output_en_o}, 32'h0, "low pin disables");
    u_pin.drive(1'b1, 4);
    chk({31'h0, output_en_o}, 32'h1, "high pin enables again");
    // Second reset with both setup switches set and a saved ignored policy.
    setup_out_off_i    <= 1'b1;
    setup_analog_off_i <= 1'b1;
    nv_policy_valid_i  <= 1'b1;
    nv_policy_i        <= POL_PIN_IGNORED;
    rstn_i             <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({30'h0, analog_ctl_en_o, output_en_o}, 32'h3, "state in reset");
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({30'h0, analog_ctl_en_o, output_en_o}, 32'h0, "setup switch defaults");
    rd(ADDR_PIN_POLICY, 32'(POL_PIN_IGNORED), "saved policy at power-up");
    rd(ADDR_PIN_STATE, 32'h1, "pin state after second reset");
    pol = 5;
    pin = 1;
    exp_out = 0;
    command(1, 1'b0);
    chk({31'h0, output_en_o}, exp_out, "on under ignored policy");
    test_done();
  end
endmodule
